// ### hw/sleep_wake_ctrl.sv
// sleep state machine with wake gating, fans, supply and indicator control
// assumes standby clock clk_sys_i and an avalon-mm master with waitrequest
`timescale 1ns/1ps
`include "sleep_wake_params.svh"

module sleep_wake_ctrl
(
   input  wire logic                     clk_sys_i,
   input  wire logic                     nrst_i,
   input  wire logic [`SW_ADDR_W-1:0]    avs_address_i,
   input  wire logic                     avs_read_i,
   input  wire logic                     avs_write_i,
   input  wire logic [31:0]              avs_writedata_i,
   input  wire logic [3:0]               avs_byteenable_i,
   output logic      [31:0]              avs_readdata_o,
   output logic                          avs_waitrequest_o,
   input  wire logic                     lan_wake_i,
   input  wire logic                     pme_n_i,
   input  wire logic                     pwr_switch_i,
   input  wire logic                     rtc_alarm_i,
   input  wire logic                     serial_wake_i,
   input  wire logic                     usb_wake_i,
   input  wire logic                     pcie_wake_n_i,
   input  wire logic                     ac_return_i,
   input  wire logic                     led_dual_i,
   output logic                          main_pwr_on_o,
   output logic                          fan_on_o,
   output logic                          led_green_o,
   output logic                          led_amber_o,
   output logic                          irq_o
);
   ////////////////////////////////////////////////////////////////////////
   logic [`SW_SRC_N-1:0] raw_w;
   logic [`SW_SRC_N-1:0] src_s;
   logic [`SW_SRC_N-1:0] src_prev_q;
   logic [`SW_SRC_N-1:0] rise_w;
   logic [`SW_SRC_N-1:0] ok_w;
   logic                 wake_w;
   logic [2:0]           cfg_q;
   logic                 saved_on_q;
   logic                 ac_prev_q;
   logic                 ac_rise_w;
   logic [`SW_IRQ_W-1:0] stat_q;
   logic [`SW_IRQ_W-1:0] mask_q;
   logic                 ack_q;
   logic                 wr_w;
   logic                 rd_w;
   logic                 cmd_w;
   sleep_wake_pkg::pwr_state_e state_q;
   sleep_wake_pkg::pwr_state_e state_d;

   // which sources each state accepts, pme and lan s5 gated by config
   function automatic logic [`SW_SRC_N-1:0] allowed
   (
      input sleep_wake_pkg::pwr_state_e st,
      input logic [2:0]                 cfg
   );
      logic [`SW_SRC_N-1:0] m;
      m = '0;
      case (st)
         sleep_wake_pkg::ST_S1, sleep_wake_pkg::ST_S3:
            m = 7'h77;
         sleep_wake_pkg::ST_S4:
            m = 7'h4F;
         sleep_wake_pkg::ST_S5:
            m = {1'b1, 2'b00, 1'b1, 1'b1, cfg[`SW_CFG_S5_LAN],
                 cfg[`SW_CFG_S5_LAN]};
         default:
            m = '0;
      endcase
      m[`SW_SRC_PME] = m[`SW_SRC_PME] & cfg[`SW_CFG_PME_EN];
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // lan line arrives already asserted by the lan subsystem
   assign raw_w = {~pcie_wake_n_i, usb_wake_i, serial_wake_i, rtc_alarm_i,
                   pwr_switch_i, ~pme_n_i, lan_wake_i};

   wake_sync #(.W(`SW_SRC_N)) u_sync
   (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .async_i   (raw_w),
      .sync_o    (src_s)
   );

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         src_prev_q <= '0;
         ac_prev_q  <= 1'b0;
      end
      else
      begin
         src_prev_q <= src_s;
         ac_prev_q  <= ac_return_i;
      end
   end

   // edges only, so a held switch does not re-wake right after sleep
   assign rise_w    = src_s & ~src_prev_q;
   assign ok_w      = rise_w & allowed(state_q, cfg_q);
   assign wake_w    = |ok_w;
   assign ac_rise_w = ac_return_i & ~ac_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // bus: one wait cycle, answer on the second edge of a request
   assign wr_w  = avs_write_i & ack_q;
   assign rd_w  = avs_read_i & ack_q;
   assign cmd_w = wr_w && avs_address_i == `SW_OFF_CTRL
                  && avs_byteenable_i[0];

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ack_q <= 1'b0;
      else
         ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         avs_waitrequest_o <= 1'b1;
      else
         avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_q);
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cfg_q  <= `SW_CFG_RESET;
         mask_q <= '0;
      end
      else if (wr_w && avs_byteenable_i[0])
      begin
         if (avs_address_i == `SW_OFF_CFG)
            cfg_q <= avs_writedata_i[2:0];
         if (avs_address_i == `SW_OFF_IRQ_MASK)
            mask_q <= avs_writedata_i[`SW_IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         avs_readdata_o <= '0;
      else if ((avs_read_i | avs_write_i) & ~ack_q)
      begin
         avs_readdata_o <= '0;
         if (avs_read_i)
            case (avs_address_i)
               `SW_OFF_CFG:      avs_readdata_o <= {29'h0, cfg_q};
               `SW_OFF_STATE:    avs_readdata_o <= {26'h0, state_q};
               `SW_OFF_IRQ_STAT: avs_readdata_o <= {24'h0, stat_q};
               `SW_OFF_IRQ_MASK: avs_readdata_o <= {24'h0, mask_q};
               `SW_OFF_SAVED:    avs_readdata_o <= {31'h0, saved_on_q};
               default:          avs_readdata_o <= '0;
            endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         sleep_wake_pkg::ST_S0:
         begin
            if (cmd_w && avs_writedata_i[`SW_CTRL_SOFT_OFF])
               state_d = sleep_wake_pkg::ST_S5;
            else if (cmd_w && avs_writedata_i[`SW_CTRL_SLEEP_S4])
               state_d = sleep_wake_pkg::ST_S4;
            else if (cmd_w && avs_writedata_i[`SW_CTRL_SLEEP_S3])
               state_d = sleep_wake_pkg::ST_S3;
            else if (cmd_w && avs_writedata_i[`SW_CTRL_SLEEP_S1])
               state_d = sleep_wake_pkg::ST_S1;
         end
         sleep_wake_pkg::ST_S1, sleep_wake_pkg::ST_S3,
         sleep_wake_pkg::ST_S4, sleep_wake_pkg::ST_S5:
            if (wake_w)
               state_d = sleep_wake_pkg::ST_S0;
         sleep_wake_pkg::ST_OFF:
            if (ac_rise_w)
               state_d = (cfg_q[`SW_CFG_RESTORE] && saved_on_q)
                         ? sleep_wake_pkg::ST_S0
                         : sleep_wake_pkg::ST_S5;
         default:
            state_d = sleep_wake_pkg::ST_OFF;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state_q <= sleep_wake_pkg::ST_OFF;
      else
         state_q <= state_d;
   end

   // last on/off state kept for restore after the ac outage
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         saved_on_q <= 1'b0;
      else if (state_q != sleep_wake_pkg::ST_OFF)
         saved_on_q <= state_q == sleep_wake_pkg::ST_S0;
      else if (wr_w && avs_address_i == `SW_OFF_SAVED)
         saved_on_q <= avs_writedata_i[0];
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         main_pwr_on_o <= 1'b0;
         fan_on_o      <= 1'b0;
         led_green_o   <= 1'b0;
         led_amber_o   <= 1'b0;
      end
      else
      begin
         main_pwr_on_o <= state_d == sleep_wake_pkg::ST_S0
                          || state_d == sleep_wake_pkg::ST_S1;
         fan_on_o      <= state_d == sleep_wake_pkg::ST_S0;
         led_green_o   <= state_d == sleep_wake_pkg::ST_S0;
         led_amber_o   <= state_d == sleep_wake_pkg::ST_S3
                          && led_dual_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // set beats the read-clear so a coincident event survives
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         stat_q <= '0;
      else
         stat_q <= (rd_w && avs_address_i == `SW_OFF_IRQ_STAT ? '0 : stat_q)
                   | {cmd_w, ok_w};
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(stat_q & mask_q);
   end

   ////////////////////////////////////////////////////////////////////////
   a_fans_follow_s0: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      1'b1 |=> fan_on_o == (state_q == sleep_wake_pkg::ST_S0))
      else $error("fan output disagrees with s0");
   a_fans_off_sleep: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      state_q inside {sleep_wake_pkg::ST_S3, sleep_wake_pkg::ST_S4,
      sleep_wake_pkg::ST_S5} && !wake_w |=> !fan_on_o)
      else $error("fans on in deep sleep");
   a_rtc_not_s1s3: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      state_q inside {sleep_wake_pkg::ST_S1, sleep_wake_pkg::ST_S3}
      |-> !ok_w[`SW_SRC_RTC])
      else $error("rtc accepted in s1 or s3");
   a_usb_only_s1s3: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      ok_w[`SW_SRC_USB] |-> state_q inside {sleep_wake_pkg::ST_S1,
      sleep_wake_pkg::ST_S3})
      else $error("usb wake outside s1 and s3");
   a_lan_s5_gate: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      state_q == sleep_wake_pkg::ST_S5 && !cfg_q[`SW_CFG_S5_LAN]
      |-> !ok_w[`SW_SRC_LAN] && !ok_w[`SW_SRC_PME])
      else $error("lan or pme woke s5 while disabled");
   a_pme_enable: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      ok_w[`SW_SRC_PME] |-> cfg_q[`SW_CFG_PME_EN])
      else $error("pme wake without enable");
   a_pcie_wakes: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      rise_w[`SW_SRC_PCIE] && state_q inside {sleep_wake_pkg::ST_S1,
      sleep_wake_pkg::ST_S3, sleep_wake_pkg::ST_S4, sleep_wake_pkg::ST_S5}
      |=> state_q == sleep_wake_pkg::ST_S0 ##1 main_pwr_on_o)
      else $error("pcie wake ignored");
   a_soft_off: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      state_q == sleep_wake_pkg::ST_S0 && cmd_w
      && avs_writedata_i[`SW_CTRL_SOFT_OFF] |=> !main_pwr_on_o
      && state_q == sleep_wake_pkg::ST_S5)
      else $error("soft off left main supply on");
   a_s3_dark: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      state_q == sleep_wake_pkg::ST_S3 && $past(state_q)
      == sleep_wake_pkg::ST_S3 |-> !main_pwr_on_o && !led_green_o)
      else $error("s3 supply or indicator wrong");
   a_restore_on: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      state_q == sleep_wake_pkg::ST_OFF && ac_rise_w
      && cfg_q[`SW_CFG_RESTORE] && saved_on_q
      |=> state_q == sleep_wake_pkg::ST_S0)
      else $error("power state not restored");
   a_s3_resume: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      state_q == sleep_wake_pkg::ST_S3 && wake_w
      |=> state_q == sleep_wake_pkg::ST_S0)
      else $error("s3 wake did not resume s0");
   a_s0_ignores: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      state_q == sleep_wake_pkg::ST_S0 |-> ok_w == '0)
      else $error("wake acted on in s0");
endmodule

// ### hw/sleep_wake_params.svh
// constants for the sleep and wake controller: register map, fields, resets
// assumes a 32-bit avalon-mm slave with word-aligned byte addresses
`ifndef SLEEP_WAKE_PARAMS_SVH
`define SLEEP_WAKE_PARAMS_SVH

`define SW_ADDR_W        6
`define SW_OFF_CTRL      6'h00
`define SW_OFF_CFG       6'h04
`define SW_OFF_STATE     6'h08
`define SW_OFF_IRQ_STAT  6'h0C
`define SW_OFF_IRQ_MASK  6'h10
`define SW_OFF_SAVED     6'h14

// ctrl fields (write-only command strobes)
`define SW_CTRL_SLEEP_S1 0
`define SW_CTRL_SLEEP_S3 1
`define SW_CTRL_SLEEP_S4 2
`define SW_CTRL_SOFT_OFF 3

// cfg fields
`define SW_CFG_PME_EN    0
`define SW_CFG_S5_LAN    1
`define SW_CFG_RESTORE   2
`define SW_CFG_RESET     3'h0

// wake source bit positions, also irq status bits 0..6
`define SW_SRC_N         7
`define SW_SRC_LAN       0
`define SW_SRC_PME       1
`define SW_SRC_PWRSW     2
`define SW_SRC_RTC       3
`define SW_SRC_SERIAL    4
`define SW_SRC_USB       5
`define SW_SRC_PCIE      6
`define SW_IRQ_SLEEP     7
`define SW_IRQ_W         8

`endif

// ### hw/sleep_wake_pkg.sv
// types for the sleep and wake controller
// state encodings are fixed here, not taken from sleep_wake_params.svh
package sleep_wake_pkg;
   typedef enum logic [5:0]
   {
      ST_S0  = 6'h01,
      ST_S1  = 6'h02,
      ST_S3  = 6'h04,
      ST_S4  = 6'h08,
      ST_S5  = 6'h10,
      ST_OFF = 6'h20
   } pwr_state_e;
endpackage

// ### hw/wake_sync.sv
// two-flop synchroniser for a vector of wake inputs
// assumes inputs are asynchronous levels, active high after inversion
`timescale 1ns/1ps
module wake_sync
#(
   parameter int W = 7
)
(
   input  wire logic         clk_sys_i,
   input  wire logic         nrst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_q <= '0;
         sync_o <= '0;
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// ### sim/wake_src_model.sv
// behavioural far side: wake sources and the ac mains sense line
// assumes the bench raises one request bit per source, active high
`timescale 1ns/1ps
`include "sleep_wake_params.svh"
module wake_src_model
(
   input  wire logic [6:0] req_i,
   input  wire logic       ac_req_i,
   output logic            lan_wake_o,
   output logic            pme_n_o,
   output logic            pwr_switch_o,
   output logic            rtc_alarm_o,
   output logic            serial_wake_o,
   output logic            usb_wake_o,
   output logic            pcie_wake_n_o,
   output logic            ac_return_o
);
   ////////////////////////////////////////////////////////////////////////
   // lan adapter raises its wake line on a wake packet seen on the wire
   assign lan_wake_o    = req_i[`SW_SRC_LAN];
   // open-drain lines: released means pulled up, never a stale low
   assign pme_n_o       = ~req_i[`SW_SRC_PME];
   assign pcie_wake_n_o = ~req_i[`SW_SRC_PCIE];
   assign pwr_switch_o  = req_i[`SW_SRC_PWRSW];
   assign rtc_alarm_o   = req_i[`SW_SRC_RTC];
   assign serial_wake_o = req_i[`SW_SRC_SERIAL];
   assign usb_wake_o    = req_i[`SW_SRC_USB];
   assign ac_return_o   = ac_req_i;
endmodule

// ### sim/tb_top.sv
// self-checking bench: avalon-mm accesses plus wake source stimulus
// assumes the controller and the wake source model compiled before it
`timescale 1ns/1ps
`include "sleep_wake_params.svh"
module tb_top;
   logic        clk_sys_i = 1'b0;
   logic        nrst_i    = 1'b0;
   logic [5:0]  addr      = 6'h00;
   logic        rd        = 1'b0;
   logic        wr        = 1'b0;
   logic [31:0] wdata     = 32'h00000000;
   logic [31:0] rdata;
   logic        wait_o;
   logic [6:0]  req       = 7'h00;
   logic        ac_req    = 1'b0;
   logic        dual      = 1'b1;
   logic        lan, pme_n, pwrsw, rtc, ser, usb, pcie_n, ac;
   logic        main_o, fan_o, green_o, amber_o, irq;
   logic [31:0] tmp;
   logic [2:0]  cfg;
   logic        w;
   int          failures  = 0;
   int          checks    = 0;
   int          cycles    = 0;
   sleep_wake_pkg::pwr_state_e sl [4] = '{sleep_wake_pkg::ST_S1,
      sleep_wake_pkg::ST_S3, sleep_wake_pkg::ST_S4, sleep_wake_pkg::ST_S5};

   always #2.5 clk_sys_i = ~clk_sys_i;

   wake_src_model src (.req_i(req), .ac_req_i(ac_req), .lan_wake_o(lan),
      .pme_n_o(pme_n), .pwr_switch_o(pwrsw), .rtc_alarm_o(rtc),
      .serial_wake_o(ser), .usb_wake_o(usb), .pcie_wake_n_o(pcie_n),
      .ac_return_o(ac));
   sleep_wake_ctrl dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
      .lan_wake_i(lan), .pme_n_i(pme_n), .pwr_switch_i(pwrsw),
      .rtc_alarm_i(rtc), .serial_wake_i(ser), .usb_wake_i(usb),
      .pcie_wake_n_i(pcie_n), .ac_return_i(ac), .led_dual_i(dual),
      .main_pwr_on_o(main_o), .fan_on_o(fan_o), .led_green_o(green_o),
      .led_amber_o(amber_o), .irq_o(irq));

   ////////////////////////////////////////////////////////////////////////
   task summarize;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // whole run needs under two thousand cycles; ceiling leaves ample margin
   always @(posedge clk_sys_i)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         failures = failures + 1;
         summarize();
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // request held until waitrequest is sampled low, then released;
   // only the cycle ceiling ends a wait that never gets its answer
   task xfer(input logic wn, input logic [5:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      rd    <= ~wn;
      wr    <= wn;
      do
         @(posedge clk_sys_i);
      while (wait_o !== 1'b0);
      tmp = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task rd_chk(input logic [5:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h00000000);
      check(tmp, exp);
   endtask

   // pins are read mid-cycle, clear of the edge that moves them
   task out_chk(input logic [3:0] exp);
      @(negedge clk_sys_i);
      check({28'h0000000, main_o, fan_o, green_o, amber_o}, {28'h0, exp});
      @(posedge clk_sys_i);
   endtask

   task irq_chk(input logic exp);
      @(negedge clk_sys_i);
      check({31'h0, irq}, {31'h0, exp});
      @(posedge clk_sys_i);
   endtask

   // one clean rising edge; the input crosses a 2-flop synchroniser
   task wake(input int b);
      req[b] <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      req[b] <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
   endtask

   task ac_pulse;
      ac_req <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      ac_req <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
   endtask

   task do_reset;
      nrst_i <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(posedge clk_sys_i);
   endtask

   function automatic logic [31:0] st(sleep_wake_pkg::pwr_state_e s);
      return {26'h0000000, s};
   endfunction

   // s: 0 = S1, 1 = S3, 2 = S4, 3 = S5
   function automatic logic ok(input int s, input int b, input logic [2:0] c);
      case (b)
         `SW_SRC_LAN:    ok = s < 3 || c[`SW_CFG_S5_LAN];
         `SW_SRC_PME:    ok = c[0] && (s < 3 || c[`SW_CFG_S5_LAN]);
         `SW_SRC_RTC:    ok = s >= 2;
         `SW_SRC_SERIAL: ok = s < 2;
         `SW_SRC_USB:    ok = s < 2;
         default:        ok = 1'b1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      do_reset();
      out_chk(4'b0000);
      rd_chk(`SW_OFF_CFG, 32'h00000000);
      rd_chk(6'h3C, 32'h00000000);
      ac_pulse();
      rd_chk(`SW_OFF_STATE, st(sleep_wake_pkg::ST_S5));
      wake(`SW_SRC_PWRSW);
      rd_chk(`SW_OFF_STATE, st(sleep_wake_pkg::ST_S0));
      $display("test reset and first wake done");
      for (int p = 0; p < 2; p++)
      begin
         cfg = p[0] ? 3'b011 : 3'b000;
         dual <= p[0];
         xfer(1'b1, `SW_OFF_CFG, {29'h0, cfg});
         for (int s = 0; s < 4; s++)
            for (int b = 0; b < `SW_SRC_N; b++)
            begin
               xfer(1'b1, `SW_OFF_CTRL, 32'h1 << s);
               rd_chk(`SW_OFF_STATE, st(sl[s]));
               out_chk(s == 0 ? 4'b1000 : {3'b000, s == 1 && dual});
               w = ok(s, b, cfg);
               wake(b);
               rd_chk(`SW_OFF_STATE,
                  w ? st(sleep_wake_pkg::ST_S0) : st(sl[s]));
               if (!w)
                  wake(`SW_SRC_PWRSW);
               rd_chk(`SW_OFF_STATE, st(sleep_wake_pkg::ST_S0));
               out_chk(4'b1110);
            end
      end
      $display("test wake permission table done");
      rd_chk(`SW_OFF_CTRL, 32'h00000000);
      // every source and the command strobe have fired by now
      rd_chk(`SW_OFF_IRQ_STAT, 32'h000000FF);
      wake(`SW_SRC_RTC);
      rd_chk(`SW_OFF_STATE, st(sleep_wake_pkg::ST_S0));
      rd_chk(`SW_OFF_IRQ_STAT, 32'h00000000);
      xfer(1'b1, `SW_OFF_IRQ_MASK, 32'h1 << `SW_SRC_PWRSW);
      rd_chk(`SW_OFF_IRQ_MASK, 32'h00000004);
      xfer(1'b1, `SW_OFF_CTRL, 32'h00000001);
      irq_chk(1'b0);
      wake(`SW_SRC_PWRSW);
      irq_chk(1'b1);
      rd_chk(`SW_OFF_IRQ_STAT, 32'h00000084);
      repeat (2) @(posedge clk_sys_i);
      irq_chk(1'b0);
      $display("test interrupts done");
      // saved state only writable while off, so reach off by a reset
      do_reset();
      xfer(1'b1, `SW_OFF_SAVED, 32'h00000001);
      xfer(1'b1, `SW_OFF_CFG, 32'h1 << `SW_CFG_RESTORE);
      ac_pulse();
      rd_chk(`SW_OFF_STATE, st(sleep_wake_pkg::ST_S0));
      out_chk(4'b1110);
      $display("test restore after ac loss done");
      summarize();
   end
endmodule
